// >>> pkg/vrc_pkg.sv
// shared constants for the voltage reference control block
package vrc_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFS_LADDER    = 4'h0;
  localparam logic [3:0]  OFS_FIXED     = 4'h4;
  localparam logic [7:0]  LADDER_RESET  = 8'h00;
  localparam logic [7:0]  FIXED_RESET   = 8'h00;
  localparam int          BIT_EN        = 7;
  localparam int          BIT_PIN       = 6;
  localparam int          BIT_RANGE     = 5;
  localparam int          BIT_SRC       = 4;
  localparam int          LVL_W         = 4;
  localparam int          BIT_FEN       = 7;
  localparam int          BIT_FST       = 6;
  localparam int          CLK_MHZ       = 100;
  localparam int          SETTLE_US     = 10;
  localparam int          SETTLE_CYC    = SETTLE_US * CLK_MHZ;
  localparam int          CNT_W         = 16;
  // output voltage in 1/96 of the source voltage, 96 = lcm of 24, 32 and 4
  localparam logic [7:0]  STEP_LOW      = 8'h04;
  localparam logic [7:0]  STEP_HIGH     = 8'h03;
  localparam logic [7:0]  QUARTER       = 8'h18;
endpackage

// >>> logic/vrc_sync.sv
// two-flop synchroniser for pin-side levels and power request levels
`timescale 1ns/100ps
module vrc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// >>> logic/vrc_settle.sv
// settle timer for the fixed reference stable flag
`timescale 1ns/100ps
module vrc_settle #(
  parameter int SETTLE = vrc_pkg::SETTLE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic powered_i,
  output logic      stable_o
);
  logic [vrc_pkg::CNT_W-1:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt      <= '0;
      stable_o <= 1'b0;
    end else if (ce_i) begin
      if (!powered_i) begin
        cnt      <= '0; // R18
        stable_o <= 1'b0; // R18
      end else if (cnt == vrc_pkg::CNT_W'(SETTLE - 1)) begin
        stable_o <= 1'b1; // R15
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
  a_stable_drop : assert property (@(posedge clk_i) disable iff (rst_i) // R18
    ce_i && !powered_i |=> !stable_o) else $error("stable held while unpowered");
endmodule

// >>> logic/vrc_top.sv
// voltage reference control: ladder and fixed reference registers over wishbone
//
// Overview of operation
// R1: ladder divider powered only while ladder enable is one.
// R2: range select chooses one of two ranges; level code picks 16 levels.
// R3: low range output is level times source over 24 plus low reference.
// R4: high range is quarter source plus level times source over 32 plus low ref.
// R5: source select one uses external reference pins, zero uses supply rails.
// R6: with supply source the low reference term is zero.
// R7: disabled, low range, code zero holds output at ground with no current.
// R8: pin drive bit connects the ladder output to its pin.
// R9: pin drive disables pin digital driver and input regardless of direction.
// R10: port read of that pin returns zero while it carries the reference.
// R11: wake from sleep leaves the ladder register unchanged.
// R12: reset clears enables, pin drive, range select and level code.
// R13: fixed reference enable bit powers the fixed reference.
// R14: oscillator, voltage detector or brown-out requests also power it.
// R15: stable flag reads one only after the fixed reference has settled.
// R16: fixed register bits five to zero ignore writes and read zero.
// R17: software waits or polls the stable flag before using the reference.
// R18: stable flag clears when unpowered, sets after a count of powered cycles.
`timescale 1ns/100ps
module vrc_top #(
  parameter int SETTLE = vrc_pkg::SETTLE_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [vrc_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic                       osc_request_i,
  input  wire logic                       detector_request_i,
  input  wire logic                       brownout_request_i,
  input  wire logic                       port_a_direction_i,
  input  wire logic                       pin_level_i,
  output logic                            ladder_power_o,
  output logic                            range_low_o,
  output logic                            source_external_o,
  output logic                            low_ref_from_pin_o,
  output logic      [vrc_pkg::LVL_W-1:0]  level_code_o,
  output logic      [7:0]                 ladder_fraction_o,
  output logic                            ladder_pin_drive_o,
  output logic                            pin_digital_out_en_o,
  output logic                            pin_input_en_o,
  output logic                            pin_read_o,
  output logic                            fixed_power_o,
  output logic                            fixed_stable_o
);
  typedef struct packed {
    logic [7:0]  ladder;
    logic        fen;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  frac;
  } vrc_state_t;

  vrc_state_t st;
  vrc_state_t next_st;
  logic [2:0] req_sync;
  logic       req_any;
  logic       pin_sync;
  logic       stable;
  logic       acc;
  logic       hit_ladder;
  logic       hit_fixed;
  logic [7:0] lvl8;

  vrc_sync #(.W(3)) u_req_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({osc_request_i, detector_request_i, brownout_request_i}),
    .q_o   (req_sync)
  );

  vrc_sync #(.W(1)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pin_level_i),
    .q_o   (pin_sync)
  );

  assign req_any = |req_sync; // R14

  vrc_settle #(.SETTLE(SETTLE)) u_settle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .powered_i (fixed_power_o),
    .stable_o  (stable)
  );

  assign acc        = cyc_i && stb_i && !st.ack;
  assign hit_ladder = adr_i == vrc_pkg::OFS_LADDER;
  assign hit_fixed  = adr_i == vrc_pkg::OFS_FIXED;
  assign lvl8       = {4'h0, st.ladder[vrc_pkg::LVL_W-1:0]};

  always_comb begin
    next_st     = st;
    next_st.ack = acc;
    if (acc && we_i && sel_i[0]) begin
      // no sleep input exists here, so the ladder register only changes on writes and reset
      if (hit_ladder) begin
        next_st.ladder = dat_i[7:0]; // R11
      end
      if (hit_fixed) begin
        next_st.fen = dat_i[vrc_pkg::BIT_FEN]; // R13 R16
      end
    end
    next_st.rdata = 32'h0000_0000;
    if (acc && !we_i) begin
      if (hit_ladder) begin
        next_st.rdata[7:0] = st.ladder;
      end
      if (hit_fixed) begin
        next_st.rdata[vrc_pkg::BIT_FEN] = st.fen;
        next_st.rdata[vrc_pkg::BIT_FST] = stable; // R15 R16
      end
    end
    if (st.ladder[vrc_pkg::BIT_RANGE]) begin
      next_st.frac = 8'(lvl8 * vrc_pkg::STEP_LOW); // R3
    end else begin
      next_st.frac = 8'(vrc_pkg::QUARTER + lvl8 * vrc_pkg::STEP_HIGH); // R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.ladder <= vrc_pkg::LADDER_RESET; // R12
      st.fen    <= vrc_pkg::FIXED_RESET[vrc_pkg::BIT_FEN]; // R12
      st.ack    <= 1'b0;
      st.rdata  <= 32'h0000_0000;
      st.frac   <= vrc_pkg::QUARTER;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign ack_o  = st.ack;
  assign dat_o  = st.rdata;
  assign ladder_power_o     = st.ladder[vrc_pkg::BIT_EN]; // R1 R7
  assign range_low_o        = st.ladder[vrc_pkg::BIT_RANGE]; // R2
  assign source_external_o  = st.ladder[vrc_pkg::BIT_SRC]; // R5
  assign low_ref_from_pin_o = st.ladder[vrc_pkg::BIT_SRC]; // R6
  assign level_code_o       = st.ladder[vrc_pkg::LVL_W-1:0]; // R2
  assign ladder_fraction_o  = st.frac;
  assign ladder_pin_drive_o = st.ladder[vrc_pkg::BIT_PIN]; // R8
  // direction is ignored while the reference owns the pin
  assign pin_digital_out_en_o = !st.ladder[vrc_pkg::BIT_PIN] && !port_a_direction_i; // R9
  assign pin_input_en_o       = !st.ladder[vrc_pkg::BIT_PIN]; // R9
  assign pin_read_o           = pin_sync && !st.ladder[vrc_pkg::BIT_PIN]; // R10
  assign fixed_power_o  = st.fen || req_any; // R13 R14
  assign fixed_stable_o = stable;

  // assertion helpers: bus steps and synchroniser crossings
  sequence s_take;
    ce_i && acc;
  endsequence

  sequence s_write_ladder;
    ce_i && acc && we_i && sel_i[0] && hit_ladder;
  endsequence

  sequence s_write_fixed;
    ce_i && acc && we_i && sel_i[0] && hit_fixed;
  endsequence

  sequence s_read_ladder;
    ce_i && acc && !we_i && hit_ladder;
  endsequence

  sequence s_read_fixed;
    ce_i && acc && !we_i && hit_fixed;
  endsequence

  // a request level held over the two enabled edges of its synchroniser
  sequence s_request_crossed;
    ce_i && (osc_request_i || detector_request_i || brownout_request_i) ##1 ce_i;
  endsequence

  // a high pin level held over the two enabled edges of its synchroniser
  sequence s_pin_crossed;
    ce_i && pin_level_i ##1 ce_i;
  endsequence

  // the fixed reference switching on after an unpowered cycle
  sequence s_fixed_power_on;
    ce_i && !fixed_power_o ##1 ce_i && fixed_power_o;
  endsequence

  // ladder register and output fraction
  // a ladder write lands in the register with its acknowledge
  a_write_ladder : assert property (@(posedge clk_i) disable iff (rst_i) // R11
    s_write_ladder |=> ack_o && st.ladder == $past(dat_i[7:0]))
    else $error("ladder write lost");

  // divider power follows the written enable bit
  a_ladder_power : assert property (@(posedge clk_i) disable iff (rst_i) // R1
    s_write_ladder |=> ladder_power_o == $past(dat_i[vrc_pkg::BIT_EN]))
    else $error("ladder power mismatch");

  // range select follows the written bit
  a_range_follow : assert property (@(posedge clk_i) disable iff (rst_i) // R2
    s_write_ladder |=> range_low_o == $past(dat_i[vrc_pkg::BIT_RANGE]))
    else $error("range select not applied");

  // level code follows the written field
  a_level_follow : assert property (@(posedge clk_i) disable iff (rst_i) // R2
    s_write_ladder |=> level_code_o == $past(dat_i[vrc_pkg::LVL_W-1:0]))
    else $error("level code not applied");

  // source select follows the written bit
  a_source_sel : assert property (@(posedge clk_i) disable iff (rst_i) // R5
    s_write_ladder |=> source_external_o == $past(dat_i[vrc_pkg::BIT_SRC]))
    else $error("source select not applied");

  // supply source drops the low reference term
  a_low_ref_zero : assert property (@(posedge clk_i) disable iff (rst_i) // R6
    s_write_ladder ##0 !dat_i[vrc_pkg::BIT_SRC] |=> !low_ref_from_pin_o)
    else $error("low reference term not zeroed");

  // low range: four ninety-sixths per level step
  a_low_range : assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && range_low_o |=> st.frac == 8'($past(lvl8) * vrc_pkg::STEP_LOW))
    else $error("low range fraction wrong");

  // high range: a quarter plus three ninety-sixths per level step
  a_high_range : assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ce_i && !range_low_o |=>
      st.frac == 8'(vrc_pkg::QUARTER + $past(lvl8) * vrc_pkg::STEP_HIGH))
    else $error("high range fraction wrong");

  // disabled, low range, code zero: no power and a zero fraction
  a_clamp_ground : assert property (@(posedge clk_i) disable iff (rst_i) // R7
    ce_i && st.ladder == 8'(1 << vrc_pkg::BIT_RANGE) |-> !ladder_power_o ##1 st.frac == 8'h00)
    else $error("clamp setting not at ground");

  // reset clears both registers and the bus answer
  a_reset_clear : assert property (@(posedge clk_i) // R12
    rst_i |=> st.ladder == vrc_pkg::LADDER_RESET && !st.fen && !ack_o && dat_o == '0)
    else $error("reset did not clear");

  // pin override
  // pin drive follows the written bit
  a_pin_drive : assert property (@(posedge clk_i) disable iff (rst_i) // R8
    s_write_ladder |=> ladder_pin_drive_o == $past(dat_i[vrc_pkg::BIT_PIN]))
    else $error("pin drive not applied");

  // while the reference owns the pin its digital side is off and reads zero
  a_pin_override : assert property (@(posedge clk_i) disable iff (rst_i) // R9 R10
    ladder_pin_drive_o |-> !pin_digital_out_en_o && !pin_input_en_o && !pin_read_o)
    else $error("pin override failed");

  // released pin goes back to its direction setting
  a_pin_digital : assert property (@(posedge clk_i) disable iff (rst_i) // R9
    !ladder_pin_drive_o |-> pin_input_en_o && pin_digital_out_en_o == !port_a_direction_i)
    else $error("pin digital path wrong");

  // a digital pin reads its synchronised level
  a_pin_read_pass : assert property (@(posedge clk_i) disable iff (rst_i) // R10
    s_pin_crossed |=> ladder_pin_drive_o || pin_read_o)
    else $error("pin level not read");

  // fixed reference
  // setting the enable bit powers the fixed reference
  a_fixed_enable : assert property (@(posedge clk_i) disable iff (rst_i) // R13
    s_write_fixed ##0 dat_i[vrc_pkg::BIT_FEN] |=> fixed_power_o)
    else $error("fixed enable did not power");

  // only the enable bit of the fixed register is stored
  a_fixed_write : assert property (@(posedge clk_i) disable iff (rst_i) // R16
    s_write_fixed |=> st.fen == $past(dat_i[vrc_pkg::BIT_FEN]))
    else $error("fixed enable write lost");

  // any crossed request powers the fixed reference
  a_fixed_req : assert property (@(posedge clk_i) disable iff (rst_i) // R14
    s_request_crossed |=> fixed_power_o)
    else $error("request did not power fixed ref");

  // fixed register reads enable, stable flag and zeros
  a_fixed_read : assert property (@(posedge clk_i) disable iff (rst_i) // R15
    s_read_fixed |=> dat_o[vrc_pkg::BIT_FST-1:0] == '0 && dat_o[31:8] == '0 &&
      dat_o[vrc_pkg::BIT_FST] == $past(stable) && dat_o[vrc_pkg::BIT_FEN] == $past(st.fen))
    else $error("fixed register read wrong");

  // no stable flag without power
  a_stable_unpowered : assert property (@(posedge clk_i) disable iff (rst_i) // R18
    ce_i && !fixed_power_o |=> !fixed_stable_o)
    else $error("stable flag while unpowered");

  // a fresh power-up is not stable on its first powered edge
  a_stable_waits : assert property (@(posedge clk_i) disable iff (rst_i) // R15
    s_fixed_power_on |=> SETTLE < 2 || !fixed_stable_o)
    else $error("stable flag set too early");

  // bus handshake
  // every taken request is acknowledged in the next cycle
  a_ack_next : assert property (@(posedge clk_i) disable iff (rst_i)
    s_take |=> ack_o)
    else $error("acknowledge late");

  // acknowledge lasts one enabled cycle
  a_ack_pulse : assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ack_o |=> !ack_o)
    else $error("acknowledge held");

  // read data is zero outside an acknowledge
  a_data_idle : assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == '0)
    else $error("read data outside acknowledge");

  // a ladder read returns the register in the low byte
  a_ladder_read : assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_ladder |=> dat_o == 32'($past(st.ladder)))
    else $error("ladder read wrong");

  // unmapped reads return zero
  a_unmapped_read : assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc && !we_i && !hit_ladder && !hit_fixed |=> dat_o == '0)
    else $error("unmapped read not zero");

  // unmapped writes change nothing
  a_unmapped_write : assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc && we_i && !hit_ladder && !hit_fixed |=> $stable(st.ladder) && $stable(st.fen))
    else $error("unmapped write landed");

  // writes without lane zero change nothing
  a_sel_ignore : assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc && we_i && !sel_i[0] |=> $stable(st.ladder) && $stable(st.fen))
    else $error("write without lane landed");

  // a low clock enable freezes all state
  a_ce_freeze : assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st))
    else $error("state moved while disabled");

endmodule

// >>> sim/vrc_top_tb_top.sv
// self-checking bench for the voltage reference control block
`timescale 1ns/100ps
module vrc_top_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1, ce_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic        ack_o, osc_i = 1'b0, det_i = 1'b0, bor_i = 1'b0, dir_i = 1'b0, pin_i = 1'b0;
  logic        pwr, rlow, sext, lref, pdrv, dout_en, in_en, prd, fpwr, fst;
  logic [3:0]  lvl;
  logic [7:0]  frac;
  int          n_errors = 0, samples_checked = 0, i, r, k;
  logic [31:0] q;

  always #5 clk_i = ~clk_i;

  vrc_top #(.SETTLE(8)) vrc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .osc_request_i(osc_i), .detector_request_i(det_i), .brownout_request_i(bor_i),
    .port_a_direction_i(dir_i), .pin_level_i(pin_i), .ladder_power_o(pwr),
    .range_low_o(rlow), .source_external_o(sext), .low_ref_from_pin_o(lref),
    .level_code_o(lvl), .ladder_fraction_o(frac), .ladder_pin_drive_o(pdrv),
    .pin_digital_out_en_o(dout_en), .pin_input_en_o(in_en), .pin_read_o(prd),
    .fixed_power_o(fpwr), .fixed_stable_o(fst));

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rq);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (n == 20) begin
      chk(1, 0, "no ack");
      final_report();
    end
    rq = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] t;
    wb(1'b1, a, d, 4'h1, t);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] t;
    wb(1'b0, a, 32'h0000_0000, 4'h1, t);
    chk(t, e, "read data");
  endtask

  // let registered and synchronised outputs settle
  task automatic settle;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    settle();
    chk(frac, 8'h18, "high range zero");
    chk({pwr, rlow, pdrv, fpwr, fst}, 5'h00, "reset outputs");
    $display("reset test done");
    for (r = 0; r < 2; r++) begin
      for (i = 0; i < 16; i++) begin
        wr(4'h0, 32'h0000_0080 | (r << 5) | i);
        settle();
        chk(frac, r ? 8'(i * (96 / 24)) : 8'(96 / 4 + i * (96 / 32)), "fraction");
        chk({pwr, rlow, lvl}, {1'b1, r[0], i[3:0]}, "level and range");
        rd(4'h0, 32'h0000_0080 | (r << 5) | i);
      end
    end
    $display("range test done");
    wr(4'h0, 32'h0000_0020);
    settle();
    chk({pwr, frac}, 9'h000, "clamp to ground");
    wr(4'h0, 32'h0000_0010);
    settle();
    chk({sext, lref}, 2'b11, "external source");
    wr(4'h0, 32'h0000_0000);
    settle();
    chk({sext, lref}, 2'b00, "supply source");
    $display("source test done");
    @(posedge clk_i);
    pin_i <= 1'b1;
    settle();
    chk({dout_en, in_en, prd}, 3'b111, "pin digital");
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      dir_i <= k[0];
      wr(4'h0, 32'h0000_0040);
      settle();
      chk({pdrv, dout_en, in_en, prd}, 4'b1000, "pin analog");
    end
    wb(1'b1, 4'h0, 32'h0000_00FF, 4'h0, q);
    wr(4'h8, 32'h0000_00FF);
    rd(4'h0, 32'h0000_0040);
    rd(4'h8, 32'h0000_0000);
    $display("pin test done");
    wr(4'h4, 32'h0000_00FF);
    rd(4'h4, 32'h0000_0080);
    chk(fpwr, 1'b1, "fixed power");
    q = 32'h0000_0000;
    for (i = 0; i < 50 && q[6] !== 1'b1; i++) wb(1'b0, 4'h4, 32'h0000_0000, 4'h1, q);
    chk(fst, 1'b1, "stable set");
    rd(4'h4, 32'h0000_00C0);
    wr(4'h4, 32'h0000_0000);
    settle();
    chk({fpwr, fst}, 2'b00, "fixed off");
    for (k = 0; k < 3; k++) begin
      @(posedge clk_i);
      {osc_i, det_i, bor_i} <= 3'b001 << k;
      settle();
      chk(fpwr, 1'b1, "request power");
      @(posedge clk_i);
      {osc_i, det_i, bor_i} <= 3'b000;
      settle();
      chk(fpwr, 1'b0, "request drop");
    end
    @(posedge clk_i);
    ce_i <= 1'b0;
    osc_i <= 1'b1;
    settle();
    chk({fpwr, fst}, 2'b00, "frozen while disabled");
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle();
    chk(fpwr, 1'b1, "request after enable");
    @(posedge clk_i);
    osc_i <= 1'b0;
    settle();
    $display("fixed test done");
    wr(4'h0, 32'h0000_00FF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    settle();
    chk({frac, pdrv, pwr}, 10'h060, "reset mid run");
    $display("mid run reset test done");
    final_report();
  end
endmodule
